// file: rtl/mssx_pkg.sv
`default_nettype none
// Shared constants and carriers of the skip, subtract, swap and exclusive-OR execution unit.
package mssx_pkg;

  // Widths of the data path, the program memory and the register bus.
  localparam int DATA_W = 8;
  localparam int PAGE_W = 9;
  localparam int PM_ADDR_W = 17;
  localparam int AXI_AW = 8;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_TBLPTR = 8'h0c;
  localparam logic [7:0] OFS_TBLHI = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;

  // Field positions of the command register.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 5;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;

  // Bit positions of the status flags.
  localparam int FL_CARRY = 0;
  localparam int FL_HALF = 1;
  localparam int FL_ZERO = 2;
  localparam int FL_OVER = 3;
  localparam int FL_PDOWN = 4;
  localparam int FL_TOUT = 5;

  // Bit positions of the status register.
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;

  // Constant values used by the execution.
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 9'h1ff;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Instruction codes carried in the command register.
  typedef enum logic [4:0] {
    OP_DEC_TO_ACC_SKIP_ZERO = 5'h00, OP_INC_SKIP_ZERO = 5'h01,
    OP_INC_TO_ACC_SKIP_ZERO = 5'h02, OP_SET_ALL = 5'h03, OP_SET_BIT = 5'h04,
    OP_SKIP_BIT_ONE = 5'h05, OP_SKIP_BIT_ZERO = 5'h06, OP_SKIP_IF_ZERO = 5'h07,
    OP_COPY_SKIP_IF_ZERO = 5'h08, OP_MINUS_TO_ACC = 5'h09, OP_MINUS_TO_MEMORY = 5'h0a,
    OP_MINUS_IMM = 5'h0b, OP_NIBBLE_EXCHANGE = 5'h0c, OP_NIBBLE_EXCHANGE_TO_ACC = 5'h0d,
    OP_TABLE_READ_CURRENT_PAGE = 5'h0e, OP_TABLE_READ_LAST_PAGE = 5'h0f,
    OP_EXCLUSIVE_OR_TO_ACC = 5'h10, OP_EXCLUSIVE_OR_TO_MEMORY = 5'h11,
    OP_EXCLUSIVE_OR_IMM = 5'h12
  } mssx_op_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_READ = 4'h2, ST_EXEC = 4'h4, ST_DUMMY = 4'h8
  } mssx_st_t;

  // Requests from the bus master.
  typedef struct packed {
    logic awvalid; logic [AXI_AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [AXI_AW-1:0] araddr; logic rready;
  } mssx_axi_req_t;

  // Answers to the bus master.
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } mssx_axi_rsp_t;

  // Requests to the data memory and the program memory.
  typedef struct packed {
    logic [7:0] dm_addr; logic dm_we; logic [7:0] dm_wdata; logic [PM_ADDR_W-1:0] pm_addr;
  } mssx_mem_req_t;

  // Whole state of the execution unit.
  typedef struct packed {
    mssx_st_t st; mssx_op_t op; logic [2:0] bitsel; logic [7:0] addr; logic [7:0] imm;
    logic [7:0] acc; logic [5:0] flags; logic [7:0] tblptr; logic [7:0] tblhi;
    logic last_skip; mssx_mem_req_t mem;
    logic aw_got; logic [AXI_AW-1:0] awaddr; logic w_got; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } mssx_state_t;

  // Reset value of the whole state.
  localparam mssx_state_t STATE_RST = '{st: ST_IDLE, op: OP_DEC_TO_ACC_SKIP_ZERO, default: '0};

endpackage
`default_nettype wire

// file: rtl/mssx_exec.sv
`default_nettype none
module mssx_exec (
  // Clock and synchronous reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // AXI4-Lite register bus.
  input wire mssx_pkg::mssx_axi_req_t axi_req,
  output var mssx_pkg::mssx_axi_rsp_t axi_rsp,
  // Page of the running program, used by the current-page table read.
  input wire logic [mssx_pkg::PAGE_W-1:0] cur_page,
  // Memory read data, valid one cycle after the address is presented.
  input wire logic [7:0] dm_rdata,
  input wire logic [15:0] pm_rdata,
  // Memory requests.
  output var mssx_pkg::mssx_mem_req_t mem_req,
  // High during the inserted dummy cycle that replaces the discarded instruction.
  output logic discard_slot
);
  import mssx_pkg::*;

  mssx_state_t s_q; // Registered state.
  mssx_state_t s_d; // Next state.
  logic skip_d; // Skip condition of the instruction in its execute cycle.
  logic busy; // An instruction is in flight.
  logic [8:0] diff; // Subtraction result with carry out.
  logic [4:0] half; // Low nibble subtraction with carry out.
  logic [7:0] opnd; // Second operand: memory byte or immediate.
  logic [7:0] res; // General result byte.

  // Merges write data into an old register value under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign busy = (s_q.st != ST_IDLE);

  // Bus handshakes: one write and one read outstanding at a time.
  always_comb begin
    axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = s_q.rdata;
    axi_rsp.rresp = s_q.rresp;
  end

  assign mem_req = s_q.mem;
  assign discard_slot = (s_q.st == ST_DUMMY);

  // Next-state logic: bus slave, sequencer and execution.
  always_comb begin
    logic [31:0] cmd_word;
    logic [31:0] nw;
    cmd_word = '0;
    nw = '0;
    s_d = s_q;
    s_d.mem.dm_we = 1'b0;
    skip_d = 1'b0;
    opnd = (s_q.op == OP_MINUS_IMM || s_q.op == OP_EXCLUSIVE_OR_IMM) ? s_q.imm : dm_rdata;
    diff = {1'b0, s_q.acc} + {1'b0, ~opnd} + 9'h001;
    half = {1'b0, s_q.acc[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
    res = '0;
    cmd_word = {8'h00, s_q.imm, s_q.addr, s_q.bitsel, s_q.op};

    // Capture write address and write data in either order.
    if (axi_req.awvalid && axi_rsp.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    // Response retires when the master takes it.
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    // Register write once both halves are held; writes are refused while busy.
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (s_q.awaddr)
        OFS_CMD: begin
          if (busy) begin
            s_d.bresp = RESP_SLVERR;
          end else begin
            nw = merge(cmd_word, s_q.wdata, s_q.wstrb);
            s_d.op = mssx_op_t'(nw[CMD_OP_LSB +: 5]);
            s_d.bitsel = nw[CMD_BIT_LSB +: 3];
            s_d.addr = nw[CMD_ADDR_LSB +: 8];
            s_d.imm = nw[CMD_IMM_LSB +: 8];
            s_d.mem.dm_addr = nw[CMD_ADDR_LSB +: 8];
            // Table reads address the word at the table pointer in the chosen page.
            if (nw[CMD_OP_LSB +: 5] == OP_TABLE_READ_LAST_PAGE) begin
              s_d.mem.pm_addr = {LAST_PAGE, s_q.tblptr};
            end else begin
              s_d.mem.pm_addr = {cur_page, s_q.tblptr};
            end
            s_d.st = ST_READ;
          end
        end
        OFS_ACC: begin
          if (busy) begin
            s_d.bresp = RESP_SLVERR;
          end else begin
            nw = merge({24'h000000, s_q.acc}, s_q.wdata, s_q.wstrb);
            s_d.acc = nw[7:0];
          end
        end
        OFS_FLAGS: begin
          if (busy) begin
            s_d.bresp = RESP_SLVERR;
          end else begin
            nw = merge({26'h0, s_q.flags}, s_q.wdata, s_q.wstrb);
            s_d.flags = nw[5:0];
          end
        end
        OFS_TBLPTR: begin
          if (busy) begin
            s_d.bresp = RESP_SLVERR;
          end else begin
            nw = merge({24'h000000, s_q.tblptr}, s_q.wdata, s_q.wstrb);
            s_d.tblptr = nw[7:0];
          end
        end
        OFS_TBLHI, OFS_STAT: begin
          s_d.bresp = RESP_SLVERR; // Read-only registers.
        end
        default: begin
          s_d.bresp = RESP_DECERR; // Unmapped address.
        end
      endcase
    end

    // Register reads answer one cycle after the address is taken.
    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = '0;
      case (axi_req.araddr)
        OFS_CMD: s_d.rdata = cmd_word;
        OFS_ACC: s_d.rdata = {24'h000000, s_q.acc};
        OFS_FLAGS: s_d.rdata = {26'h0, s_q.flags};
        OFS_TBLPTR: s_d.rdata = {24'h000000, s_q.tblptr};
        OFS_TBLHI: s_d.rdata = {24'h000000, s_q.tblhi};
        OFS_STAT: begin
          s_d.rdata[STAT_BUSY] = busy;
          s_d.rdata[STAT_SKIP] = s_q.last_skip;
        end
        default: s_d.rresp = RESP_DECERR;
      endcase
    end

    // Sequencer: read operands, execute, then a dummy cycle when skipping.
    case (s_q.st)
      ST_IDLE: begin
        s_d.st = s_d.st; // Leaves only on a command write.
      end
      ST_READ: begin
        s_d.st = ST_EXEC;
      end
      ST_EXEC: begin
        case (s_q.op)
          OP_DEC_TO_ACC_SKIP_ZERO: begin
            res = dm_rdata - 8'h01;
            s_d.acc = res;
            skip_d = (res == 8'h00);
          end
          OP_INC_SKIP_ZERO: begin
            res = dm_rdata + 8'h01;
            s_d.mem.dm_we = 1'b1;
            s_d.mem.dm_wdata = res;
            skip_d = (res == 8'h00);
          end
          OP_INC_TO_ACC_SKIP_ZERO: begin
            res = dm_rdata + 8'h01;
            s_d.acc = res;
            skip_d = (res == 8'h00);
          end
          OP_SET_ALL: begin
            s_d.mem.dm_we = 1'b1;
            s_d.mem.dm_wdata = ALL_ONES;
          end
          OP_SET_BIT: begin
            s_d.mem.dm_we = 1'b1;
            s_d.mem.dm_wdata = dm_rdata | (8'h01 << s_q.bitsel);
          end
          OP_SKIP_BIT_ONE: skip_d = dm_rdata[s_q.bitsel];
          OP_SKIP_BIT_ZERO: skip_d = !dm_rdata[s_q.bitsel];
          OP_SKIP_IF_ZERO: skip_d = (dm_rdata == 8'h00);
          OP_COPY_SKIP_IF_ZERO: begin
            s_d.acc = dm_rdata;
            skip_d = (dm_rdata == 8'h00);
          end
          OP_MINUS_TO_ACC, OP_MINUS_TO_MEMORY, OP_MINUS_IMM: begin
            // Accumulator plus inverted operand plus one.
            if (s_q.op == OP_MINUS_TO_MEMORY) begin
              s_d.mem.dm_we = 1'b1;
              s_d.mem.dm_wdata = diff[7:0];
            end else begin
              s_d.acc = diff[7:0];
            end
            s_d.flags[FL_CARRY] = diff[8];
            s_d.flags[FL_HALF] = half[4];
            s_d.flags[FL_ZERO] = (diff[7:0] == 8'h00);
            s_d.flags[FL_OVER] = (s_q.acc[7] ^ opnd[7]) & (s_q.acc[7] ^ diff[7]);
          end
          OP_NIBBLE_EXCHANGE: begin
            s_d.mem.dm_we = 1'b1;
            s_d.mem.dm_wdata = {dm_rdata[3:0], dm_rdata[7:4]};
          end
          OP_NIBBLE_EXCHANGE_TO_ACC: begin
            s_d.acc = {dm_rdata[3:0], dm_rdata[7:4]};
          end
          OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE: begin
            s_d.mem.dm_we = 1'b1;
            s_d.mem.dm_wdata = pm_rdata[7:0];
            s_d.tblhi = pm_rdata[15:8];
          end
          OP_EXCLUSIVE_OR_TO_ACC, OP_EXCLUSIVE_OR_IMM, OP_EXCLUSIVE_OR_TO_MEMORY: begin
            res = s_q.acc ^ opnd;
            if (s_q.op == OP_EXCLUSIVE_OR_TO_MEMORY) begin
              s_d.mem.dm_we = 1'b1;
              s_d.mem.dm_wdata = res;
            end else begin
              s_d.acc = res;
            end
            s_d.flags[FL_ZERO] = (res == 8'h00);
          end
          default: begin
            res = '0; // Unknown codes execute as no operation.
          end
        endcase
        s_d.last_skip = skip_d;
        s_d.st = skip_d ? ST_DUMMY : ST_IDLE;
      end
      ST_DUMMY: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks on the execution, sampled on the core clock.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic ex; // Execute cycle.
  assign ex = (s_q.st == ST_EXEC);

  sequence exec_skip_s;
    ex && skip_d;
  endsequence
  sequence dummy_then_idle_s;
    (s_q.st == ST_DUMMY) && discard_slot ##1 (s_q.st == ST_IDLE);
  endsequence

  AST_SKIP_TWO_CYCLES: assert property (exec_skip_s |=> dummy_then_idle_s)
    else $error("Skip did not insert exactly one dummy cycle.");
  AST_NOSKIP_ONE_CYCLE: assert property (ex && !skip_d |=> s_q.st == ST_IDLE && !discard_slot)
    else $error("Instruction without skip took more than one cycle.");
  AST_DEC_TO_ACC: assert property (ex && s_q.op == OP_DEC_TO_ACC_SKIP_ZERO |=>
      s_q.acc == 8'($past(dm_rdata) - 8'h01) && !mem_req.dm_we && s_q.last_skip == (s_q.acc == 8'h00))
    else $error("Decrement to accumulator wrong.");
  AST_SET_ALL: assert property (ex && s_q.op == OP_SET_ALL |=>
      mem_req.dm_we && mem_req.dm_wdata == 8'hff && $stable(s_q.flags))
    else $error("Set-all did not write all ones.");
  AST_SET_BIT: assert property (ex && s_q.op == OP_SET_BIT |=>
      mem_req.dm_wdata == ($past(dm_rdata) | (8'h01 << $past(s_q.bitsel))))
    else $error("Set-bit changed the wrong bits.");
  AST_INC_MEM: assert property (ex && s_q.op == OP_INC_SKIP_ZERO |=>
      mem_req.dm_we && mem_req.dm_wdata == 8'($past(dm_rdata) + 8'h01)
      && s_q.last_skip == ($past(dm_rdata) == 8'hff))
    else $error("Increment in place wrong.");
  AST_INC_TO_ACC: assert property (ex && s_q.op == OP_INC_TO_ACC_SKIP_ZERO |=>
      s_q.acc == 8'($past(dm_rdata) + 8'h01) && !mem_req.dm_we)
    else $error("Increment to accumulator wrong.");
  AST_SKIP_BIT_ONE: assert property (ex && s_q.op == OP_SKIP_BIT_ONE |->
      skip_d == dm_rdata[s_q.bitsel] ##1 !mem_req.dm_we && $stable(s_q.flags))
    else $error("Bit-one skip wrong.");
  AST_MINUS_FLAGS: assert property (ex && s_q.op == OP_MINUS_TO_MEMORY |=>
      mem_req.dm_wdata == 8'($past(s_q.acc) - $past(dm_rdata))
      && s_q.flags[FL_CARRY] == ($past(s_q.acc) >= $past(dm_rdata)))
    else $error("Subtract to memory wrong.");
  AST_MINUS_IMM: assert property (ex && s_q.op == OP_MINUS_IMM |=>
      s_q.acc == 8'($past(s_q.acc) - $past(s_q.imm)) && s_q.flags[FL_ZERO] == (s_q.acc == 8'h00))
    else $error("Subtract immediate wrong.");
  AST_SWAP_MEM: assert property (ex && s_q.op == OP_NIBBLE_EXCHANGE |=>
      mem_req.dm_wdata == {$past(dm_rdata[3:0]), $past(dm_rdata[7:4])})
    else $error("Nibble swap wrong.");
  AST_SWAP_ACC: assert property (ex && s_q.op == OP_NIBBLE_EXCHANGE_TO_ACC |=>
      s_q.acc[3:0] == $past(dm_rdata[7:4]) && !mem_req.dm_we)
    else $error("Nibble swap to accumulator wrong.");
  AST_SKIP_ZERO: assert property (ex && s_q.op == OP_SKIP_IF_ZERO |->
      skip_d == (dm_rdata == 8'h00))
    else $error("Zero skip wrong.");
  AST_COPY_SKIP: assert property (ex && s_q.op == OP_COPY_SKIP_IF_ZERO |=>
      s_q.acc == $past(dm_rdata) && $stable(s_q.flags))
    else $error("Copy and test wrong.");
  AST_SKIP_BIT_ZERO: assert property (ex && s_q.op == OP_SKIP_BIT_ZERO |->
      skip_d != dm_rdata[s_q.bitsel])
    else $error("Bit-zero skip wrong.");
  AST_TABLE_READ: assert property (s_q.st == ST_READ && (s_q.op == OP_TABLE_READ_LAST_PAGE)
      |-> mem_req.pm_addr == {LAST_PAGE, s_q.tblptr} ##1 1'b1 ##1 s_q.tblhi == $past(pm_rdata[15:8]))
    else $error("Last-page table read wrong.");
  AST_TABLE_CUR: assert property (ex && s_q.op == OP_TABLE_READ_CURRENT_PAGE |=>
      mem_req.dm_wdata == $past(pm_rdata[7:0]) && s_q.tblhi == $past(pm_rdata[15:8]))
    else $error("Current-page table read wrong.");
  AST_XOR_ZERO_ONLY: assert property (ex && (s_q.op == OP_EXCLUSIVE_OR_TO_ACC
      || s_q.op == OP_EXCLUSIVE_OR_IMM) |=> s_q.acc == ($past(s_q.acc) ^ $past(opnd))
      && s_q.flags[5:3] == $past(s_q.flags[5:3]) && s_q.flags[1:0] == $past(s_q.flags[1:0]))
    else $error("Exclusive-OR to accumulator wrong.");
  AST_XOR_MEM: assert property (ex && s_q.op == OP_EXCLUSIVE_OR_TO_MEMORY |=>
      mem_req.dm_we && mem_req.dm_wdata == ($past(s_q.acc) ^ $past(dm_rdata)) && $stable(s_q.acc))
    else $error("Exclusive-OR to memory wrong.");
  AST_FLAGS_KEPT: assert property (ex && s_q.op inside {OP_SKIP_IF_ZERO, OP_SET_BIT,
      OP_NIBBLE_EXCHANGE, OP_TABLE_READ_LAST_PAGE, OP_INC_SKIP_ZERO} |=> $stable(s_q.flags))
    else $error("Flags changed by a flag-neutral instruction.");

endmodule // mssx_exec
`default_nettype wire

// file: verif/tb_mcu_skip_sub_swap_xor_exec.sv
`default_nettype none
// Self-checking bench: drives the register bus, models both memories and checks results.
module tb_mcu_skip_sub_swap_xor_exec import mssx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Design ports.
  logic sys_clk;
  logic nrst;
  mssx_axi_req_t req;
  mssx_axi_rsp_t rsp;
  logic [PAGE_W-1:0] cur_page;
  logic [7:0] dm_rdata;
  logic [15:0] pm_rdata;
  mssx_mem_req_t mreq;
  logic discard_slot;
  // Data memory image, counters and a flag pattern that must survive untouched.
  logic [7:0] dmem [256];
  int n_fail, n_tests, n_disc;
  localparam logic [5:0] F0 = 6'h35;

  mssx_exec dut_u (.sys_clk(sys_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp),
    .cur_page(cur_page), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata), .mem_req(mreq),
    .discard_slot(discard_slot));

  // Clock of 5 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Memories answer one cycle after the address; program word is derived from its address.
  always @(posedge sys_clk) begin
    dm_rdata <= dmem[mreq.dm_addr];
    pm_rdata <= {mreq.pm_addr[15:8], mreq.pm_addr[7:0] ^ 8'h3c};
    if (mreq.dm_we === 1'b1) dmem[mreq.dm_addr] <= mreq.dm_wdata;
    if (discard_slot === 1'b1) n_disc++;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each dropped when taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 50);
    // A write that never answers counts as a mismatch.
    if (rsp.bvalid !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no write response", $time);
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Bus read: data and response are taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 50);
    // A read that never answers counts as a mismatch.
    if (rsp.rvalid !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED at %0t: no read response", $time);
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Register write that must be accepted.
  task automatic setr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask

  // Runs one instruction from a known start and checks skip, accumulator, flags and memory.
  task automatic oc(input logic [4:0] op, input logic [2:0] b, input logic [7:0] a, imm, acc0,
      input logic [5:0] f0, input logic [7:0] m0, input logic skp, input logic [7:0] acc_e,
      input logic [5:0] f_e, input logic [7:0] m_e);
    logic [31:0] d;
    logic [1:0] r;
    int c0, n;
    dmem[a] = m0;
    setr(OFS_ACC, {24'h0, acc0});
    setr(OFS_FLAGS, {26'h0, f0});
    c0 = n_disc;
    setr(OFS_CMD, {8'h00, imm, a, b, op});
    n = 0;
    d = '1;
    // Poll until idle; a hang leaves busy set and fails the status check.
    while (d[0] !== 1'b0 && n < 20) begin
      axi_rd(OFS_STAT, d, r);
      n++;
    end
    chk(d & 32'h3, {30'h0, skp, 1'b0}, "status");
    chk(32'(n_disc - c0), {31'h0, skp}, "dummy slots");
    axi_rd(OFS_ACC, d, r);
    chk(d, {24'h0, acc_e}, "accumulator");
    axi_rd(OFS_FLAGS, d, r);
    chk(d, {26'h0, f_e}, "flags");
    chk({24'h0, dmem[a]}, {24'h0, m_e}, "memory");
  endtask

  // Expected flags of a subtraction: carry means no borrow.
  function automatic logic [5:0] subf(input logic [5:0] f, input logic [7:0] a, m);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, ~m} + 9'h001;
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
    return {f[5:4], (a[7] != m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
  endfunction

  // Reset values, an unmapped address and a read-only register.
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(4 * i), d, r);
      chk(d, 32'h0, "reset value");
    end
    axi_rd(8'h18, d, r);
    chk({d[29:0], r}, {30'h0, RESP_DECERR}, "unmapped read");
    axi_wr(8'h18, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped write");
    axi_wr(OFS_TBLHI, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "read-only write");
  endtask

  // Decrement, increment and zero-test forms on both sides of the zero boundary.
  task automatic t_skips();
    oc(5'h00, 3'h0, 8'h10, 8'h00, 8'h55, F0, 8'h01, 1'b1, 8'h00, F0, 8'h01);
    oc(5'h00, 3'h0, 8'h10, 8'h00, 8'h55, F0, 8'h00, 1'b0, 8'hff, F0, 8'h00);
    oc(5'h01, 3'h0, 8'h11, 8'h00, 8'h55, F0, 8'hff, 1'b1, 8'h55, F0, 8'h00);
    oc(5'h01, 3'h0, 8'h11, 8'h00, 8'h55, F0, 8'h7f, 1'b0, 8'h55, F0, 8'h80);
    oc(5'h02, 3'h0, 8'h12, 8'h00, 8'h55, F0, 8'hff, 1'b1, 8'h00, F0, 8'hff);
    oc(5'h02, 3'h0, 8'h12, 8'h00, 8'h55, F0, 8'hfe, 1'b0, 8'hff, F0, 8'hfe);
    oc(5'h07, 3'h0, 8'h13, 8'h00, 8'h55, F0, 8'h00, 1'b1, 8'h55, F0, 8'h00);
    oc(5'h07, 3'h0, 8'h13, 8'h00, 8'h55, F0, 8'h01, 1'b0, 8'h55, F0, 8'h01);
    oc(5'h08, 3'h0, 8'h14, 8'h00, 8'h55, F0, 8'h00, 1'b1, 8'h00, F0, 8'h00);
    oc(5'h08, 3'h0, 8'h14, 8'h00, 8'h55, F0, 8'h80, 1'b0, 8'h80, F0, 8'h80);
  endtask

  // Set-all, set-bit and both bit tests over every bit position.
  task automatic t_bits();
    logic [7:0] m;
    oc(5'h03, 3'h0, 8'h18, 8'h00, 8'h55, F0, 8'h12, 1'b0, 8'h55, F0, ALL_ONES);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      oc(5'h04, 3'(i), 8'h19, 8'h00, 8'h55, F0, 8'ha5, 1'b0, 8'h55, F0, 8'ha5 | m);
      oc(5'h05, 3'(i), 8'h1a, 8'h00, 8'h55, F0, 8'h5a, |(8'h5a & m), 8'h55, F0, 8'h5a);
      oc(5'h06, 3'(i), 8'h1a, 8'h00, 8'h55, F0, 8'h5a, ~|(8'h5a & m), 8'h55, F0, 8'h5a);
    end
  endtask

  // Subtraction forms with carry, borrow, overflow and zero results.
  task automatic t_sub();
    logic [7:0] pa [4] = '{8'h10, 8'h80, 8'h05, 8'h00};
    logic [7:0] pm [4] = '{8'h01, 8'h01, 8'h05, 8'hff};
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      s = pa[i] - pm[i];
      oc(5'h09, 3'h0, 8'h20, 8'h00, pa[i], F0, pm[i], 1'b0, s, subf(F0, pa[i], pm[i]), pm[i]);
      oc(5'h0a, 3'h0, 8'h21, 8'h00, pa[i], F0, pm[i], 1'b0, pa[i], subf(F0, pa[i], pm[i]), s);
      oc(5'h0b, 3'h0, 8'h22, pm[i], pa[i], F0, 8'h3c, 1'b0, s, subf(F0, pa[i], pm[i]), 8'h3c);
    end
  endtask

  // Nibble swaps and both table reads.
  task automatic t_swap_tab();
    logic [31:0] d;
    logic [1:0] r;
    oc(5'h0c, 3'h0, 8'h28, 8'h00, 8'h55, F0, 8'h3c, 1'b0, 8'h55, F0, 8'hc3);
    oc(5'h0d, 3'h0, 8'h29, 8'h00, 8'h55, F0, 8'h12, 1'b0, 8'h21, F0, 8'h12);
    setr(OFS_TBLPTR, 32'h77);
    @(posedge sys_clk);
    cur_page <= 9'h0a5;
    oc(5'h0e, 3'h0, 8'h2a, 8'h00, 8'h55, F0, 8'h00, 1'b0, 8'h55, F0, 8'h77 ^ 8'h3c);
    axi_rd(OFS_TBLHI, d, r);
    chk(d, 32'ha5, "table high byte");
    oc(5'h0f, 3'h0, 8'h2b, 8'h00, 8'h55, F0, 8'h00, 1'b0, 8'h55, F0, 8'h77 ^ 8'h3c);
    axi_rd(OFS_TBLHI, d, r);
    chk(d, 32'hff, "table high byte");
  endtask

  // Exclusive-OR forms: zero result sets the zero flag, others flags stay.
  task automatic t_xor();
    oc(5'h10, 3'h0, 8'h30, 8'h00, 8'h5a, 6'h3b, 8'h5a, 1'b0, 8'h00, 6'h3f, 8'h5a);
    oc(5'h10, 3'h0, 8'h30, 8'h00, 8'h5a, 6'h3f, 8'h0f, 1'b0, 8'h55, 6'h3b, 8'h0f);
    oc(5'h11, 3'h0, 8'h31, 8'h00, 8'h5a, 6'h3b, 8'h5a, 1'b0, 8'h5a, 6'h3f, 8'h00);
    oc(5'h11, 3'h0, 8'h31, 8'h00, 8'h5a, 6'h04, 8'h0f, 1'b0, 8'h5a, 6'h00, 8'h55);
    oc(5'h12, 3'h0, 8'h32, 8'h5a, 8'h5a, 6'h3b, 8'h00, 1'b0, 8'h00, 6'h3f, 8'h00);
    oc(5'h12, 3'h0, 8'h32, 8'hf0, 8'h5a, 6'h3f, 8'h00, 1'b0, 8'haa, 6'h3b, 8'h00);
    // An unused code runs as a no-operation: nothing changes and nothing is skipped.
    oc(5'h1f, 3'h0, 8'h33, 8'h00, 8'h5a, F0, 8'h77, 1'b0, 8'h5a, F0, 8'h77);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 20000 cycles.
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end

  // Main sequence: reset for two cycles, then every scenario.
  initial begin
    nrst = 1'b0;
    req = '0;
    cur_page = '0;
    foreach (dmem[i]) dmem[i] = 8'h00;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_skips();
    t_bits();
    t_sub();
    t_swap_tab();
    t_xor();
    wrap_up();
  end
endmodule // tb_mcu_skip_sub_swap_xor_exec
`default_nettype wire
